// file: rtl/dsg_pkg.sv
// package: shared constants and an io decode function for the dma bus glue ends
package dsg_pkg;
   localparam int unsigned ADDR_W       = 16;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned IO_SPACE     = 256;
   localparam int unsigned IO_LSB       = 2;              // a0/a1 left to the peripheral
   localparam int unsigned BLK_W        = 16;
   localparam logic [15:0] BLK_RST      = 16'h0000;
   localparam logic [15:0] ADDR_RST     = 16'h0000;
   localparam logic [7:0]  DATA_RST     = 8'h00;
   localparam logic [7:0]  DMA_IO_ADDR  = 8'h00;          // arbitrary default decode address
   localparam logic [7:0]  PER_IO_ADDR  = 8'h04;
   localparam logic [3:0]  TIME_RST     = 4'h0;
   localparam int unsigned TIME_W       = 4;
   // time between bus grant and first cycle, in clocks
   localparam int unsigned START_CYC    = 1;

   function automatic logic io_hit(input logic [7:0] lo, input logic [7:0] base);
      io_hit = (lo[7:IO_LSB] == base[7:IO_LSB]);
   endfunction : io_hit
endpackage : dsg_pkg

// file: rtl/dsg_bus_if.sv
// interface: shared parallel bus between the dma end and the system glue end
interface dsg_bus_if;
   logic [15:0] addr;            // address driven by dma when master
   logic        addr_oe_n;       // dma address enable, low while driving
   logic [7:0]  dma_dout;        // dma data out
   logic        dma_doe_n;       // dma data enable, low while driving
   logic [7:0]  sys_din;         // data seen by dma
   logic        mem_request_n;   // dma memory request
   logic        io_request_n;    // dma io request
   logic        rd_n;            // dma read strobe
   logic        wr_n;            // dma write strobe
   logic        ctl_oe_n;        // dma control strobe enable
   logic        bus_req_n;       // dma asks for the bus
   logic        bus_grant_ack_n; // cpu gave up the bus
   logic        grant_chain_in_n;
   logic        grant_chain_out_n;
   logic        search_mode;     // dma runs reads only (fly-by)
   logic        cs_wait_n;       // shared chip-select / wait pin into dma
   logic        t2_phase;        // dma in second state of a read or write cycle

   modport dma (
      output addr, addr_oe_n, dma_dout, dma_doe_n, mem_request_n, io_request_n,
             rd_n, wr_n, ctl_oe_n, bus_req_n, grant_chain_out_n, search_mode, t2_phase,
      input  sys_din, bus_grant_ack_n, grant_chain_in_n, cs_wait_n
   );
   modport glue (
      input  addr, addr_oe_n, dma_dout, dma_doe_n, mem_request_n, io_request_n,
             rd_n, wr_n, ctl_oe_n, bus_req_n, grant_chain_out_n, search_mode, t2_phase,
      output sys_din, bus_grant_ack_n, grant_chain_in_n, cs_wait_n
   );
endinterface : dsg_bus_if

// file: rtl/dsg_glue.sv
// module: system glue, chip-enable decode, cs/wait steering, buffers, fly-by strobes
module dsg_glue (
   input  wire logic        i_clk,             // system clock
   input  wire logic        i_rst_n,           // async reset, active low
   dsg_bus_if.glue          bus,               // dma side
   input  wire logic        i_cpu_grant_ack_n, // cpu bus grant ack
   input  wire logic        i_multi_master,    // high: use grant chain for ownership
   input  wire logic        i_chain_in_n,      // grant chain into this dma
   input  wire logic [15:0] i_cpu_addr,        // cpu address
   input  wire logic        i_cpu_io_req_n,    // cpu io request
   input  wire logic        i_cpu_fetch_n,     // cpu opcode fetch
   input  wire logic        i_cpu_rd_n,        // cpu read strobe
   input  wire logic        i_wait_request_n,  // wait from memory / io logic
   input  wire logic        i_intack_vec,      // card device supplies vector
   input  wire logic [7:0]  i_sys_data,        // data from system bus
   output logic             o_dma_cs_n,        // decoded dma select
   output logic             o_per_cs_n,        // decoded peripheral select
   output logic             o_cpu_buf_oe_n,    // cpu buffer enable, low = on
   output logic             o_dma_buf_oe_n,    // dma buffer enable, low = on
   output logic             o_data_out,        // card data buffer direction: 1 = out
   output logic             o_mem_write_fly_n, // fly-by memory write
   output logic             o_io_write_fly_n,  // fly-by io write
   output logic             o_mem_read_fly_n,  // fly-by memory read
   output logic             o_io_read_fly_n    // fly-by io read
);

   // ------------------------------------------------------------
   // ownership and decode
   // ------------------------------------------------------------
   logic dma_owner;
   logic cs_dma_n;
   logic cs_per_n;
   logic [7:0] lo;

   assign bus.bus_grant_ack_n  = i_cpu_grant_ack_n;
   assign bus.grant_chain_in_n = i_chain_in_n;
   assign bus.sys_din          = i_sys_data;

   always_comb begin
      if (i_multi_master) begin
         dma_owner = !bus.grant_chain_in_n && bus.grant_chain_out_n;
      end else begin
         dma_owner = !i_cpu_grant_ack_n;
      end
   end

   assign lo = i_cpu_addr[7:0];
   // io request kept as a term even though peripherals gate it; harmless and easier to debug
   assign cs_dma_n = !(!i_cpu_io_req_n && dsg_pkg::io_hit(lo, dsg_pkg::DMA_IO_ADDR));
   assign cs_per_n = !(!i_cpu_io_req_n && dsg_pkg::io_hit(lo, dsg_pkg::PER_IO_ADDR));
   assign o_dma_cs_n = cs_dma_n;
   assign o_per_cs_n = cs_per_n;

   // the single-dma mux keys on grant ack only, as built
   assign bus.cs_wait_n = !i_cpu_grant_ack_n ? i_wait_request_n : cs_dma_n;

   // ------------------------------------------------------------
   // buffer control
   // ------------------------------------------------------------
   assign o_cpu_buf_oe_n = dma_owner;
   assign o_dma_buf_oe_n = !dma_owner;
   always_comb begin
      o_data_out = ((!cs_dma_n || !cs_per_n) && !i_cpu_rd_n && i_cpu_fetch_n)
                 || i_intack_vec
                 || (dma_owner && !bus.wr_n);
   end

   // ------------------------------------------------------------
   // fly-by strobes
   // ------------------------------------------------------------
   logic fly_wr_hold_r;
   logic fly_wr_hold_nxt;
   logic fly_rd;

   assign fly_rd = dma_owner && bus.search_mode && !bus.rd_n;

   always_comb begin
      fly_wr_hold_nxt = fly_wr_hold_r;
      if (!fly_rd) begin
         fly_wr_hold_nxt = 1'b0;
      end else if (bus.t2_phase) begin
         fly_wr_hold_nxt = 1'b1;
      end
   end

   always_ff @(negedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fly_wr_hold_r <= 1'b0;
      end else begin
         fly_wr_hold_r <= fly_wr_hold_nxt;
      end
   end

   always_comb begin
      o_io_write_fly_n  = !(fly_rd && !bus.mem_request_n);
      o_mem_read_fly_n  = !(fly_rd && !bus.mem_request_n);
      o_mem_write_fly_n = !(fly_rd && !bus.io_request_n && fly_wr_hold_r);
      o_io_read_fly_n   = !(fly_rd && !bus.io_request_n);
   end
endmodule : dsg_glue

// file: rtl/dsg_dma.sv
// module: dma bus-master end, block transfer engine with cpu-like cycles
module dsg_dma (
   input  wire logic        i_clk,        // system clock
   input  wire logic        i_rst_n,      // async reset, active low
   dsg_bus_if.dma           bus,          // shared bus
   input  wire logic        i_start,      // pulse: begin a block
   input  wire logic [15:0] i_blk_len,    // programmed block length
   input  wire logic [15:0] i_src_addr,   // source start
   input  wire logic [15:0] i_dst_addr,   // destination start
   input  wire logic        i_src_io,     // source is io
   input  wire logic        i_dst_io,     // destination is io
   input  wire logic        i_search,     // search mode (fly-by)
   input  wire logic [3:0]  i_extra_wr,   // extra write strobe states
   input  wire logic        i_short,      // ignore the wait pin in t2
   output logic             o_busy,       // block running
   output logic             o_done,       // pulse: block finished
   output logic [15:0]      o_count       // bytes moved
);
   typedef enum logic [2:0] {S_IDLE, S_REQ, S_T1, S_T2, S_T3, S_EXT} dsg_st_e;
   dsg_st_e     st_r, st_nxt;
   logic        is_wr_r, is_wr_nxt;
   logic [15:0] cnt_r, cnt_nxt, len_r, len_nxt, sa_r, sa_nxt, da_r, da_nxt;
   logic [7:0]  dat_r, dat_nxt;
   logic [3:0]  ext_r, ext_nxt;
   logic        wait_s1_r, wait_s2_r;
   logic        owner;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_s1_r <= 1'b1;
         wait_s2_r <= 1'b1;
      end else begin
         wait_s1_r <= bus.cs_wait_n;
         wait_s2_r <= wait_s1_r;
      end
   end

   assign owner = !bus.bus_grant_ack_n && !bus.grant_chain_in_n;

   always_comb begin
      st_nxt = st_r;  is_wr_nxt = is_wr_r; cnt_nxt = cnt_r; len_nxt = len_r;
      sa_nxt = sa_r;  da_nxt = da_r;       dat_nxt = dat_r; ext_nxt = ext_r;
      unique case (st_r)
         S_IDLE: if (i_start) begin
            len_nxt = i_blk_len; sa_nxt = i_src_addr; da_nxt = i_dst_addr;
            cnt_nxt = dsg_pkg::BLK_RST; is_wr_nxt = 1'b0; st_nxt = S_REQ;
         end
         S_REQ:  if (owner) st_nxt = S_T1;
         S_T1:   st_nxt = S_T2;
         // wait pin sampled in t2 stretches the cycle like the cpu's
         S_T2:   if (wait_s2_r || i_short) begin
            if (is_wr_r && i_extra_wr != dsg_pkg::TIME_RST) begin
               ext_nxt = i_extra_wr; st_nxt = S_EXT;
            end else begin
               st_nxt = S_T3;
            end
         end
         S_EXT:  begin
            ext_nxt = ext_r - 4'h1;
            if (ext_r == 4'h1) st_nxt = S_T3;
         end
         S_T3:   begin
            if (!is_wr_r) begin
               dat_nxt = bus.sys_din;
               if (i_search) begin
                  // fly-by: read only, no write cycle
                  cnt_nxt = cnt_r + 16'h0001;
                  sa_nxt  = sa_r + 16'h0001;
                  st_nxt  = (cnt_r == len_r) ? S_IDLE : S_T1;
               end else begin
                  is_wr_nxt = 1'b1; st_nxt = S_T1;
               end
            end else begin
               is_wr_nxt = 1'b0;
               cnt_nxt = cnt_r + 16'h0001;
               if (!i_src_io) sa_nxt = sa_r + 16'h0001;
               if (!i_dst_io) da_nxt = da_r + 16'h0001;
               st_nxt = (cnt_r == len_r) ? S_IDLE : S_T1;
            end
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= S_IDLE;  is_wr_r <= 1'b0; cnt_r <= dsg_pkg::BLK_RST;
         len_r <= dsg_pkg::BLK_RST; sa_r <= dsg_pkg::ADDR_RST; da_r <= dsg_pkg::ADDR_RST;
         dat_r <= dsg_pkg::DATA_RST; ext_r <= dsg_pkg::TIME_RST;
      end else begin
         st_r <= st_nxt;  is_wr_r <= is_wr_nxt; cnt_r <= cnt_nxt;
         len_r <= len_nxt; sa_r <= sa_nxt; da_r <= da_nxt;
         dat_r <= dat_nxt; ext_r <= ext_nxt;
      end
   end

   logic cyc, port_io;
   assign cyc     = (st_r == S_T2) || (st_r == S_T3) || (st_r == S_EXT);
   assign port_io = is_wr_r ? i_dst_io : i_src_io;

   assign bus.addr          = is_wr_r ? da_r : sa_r;
   assign bus.addr_oe_n     = !(st_r != S_IDLE && st_r != S_REQ);
   assign bus.ctl_oe_n      = bus.addr_oe_n;
   assign bus.dma_dout      = dat_r;
   assign bus.dma_doe_n     = !(is_wr_r && st_r != S_IDLE && st_r != S_REQ);
   assign bus.mem_request_n = !(cyc && !port_io);
   assign bus.io_request_n  = !(cyc && port_io);
   assign bus.rd_n          = !(cyc && !is_wr_r);
   assign bus.wr_n          = !(is_wr_r && (st_r == S_T3 || st_r == S_EXT));
   assign bus.bus_req_n     = (st_r == S_IDLE);
   assign bus.grant_chain_out_n = !(bus.grant_chain_in_n == 1'b0 && st_r == S_IDLE);
   assign bus.search_mode   = i_search;
   assign bus.t2_phase      = (st_r == S_T2);
   assign o_busy  = (st_r != S_IDLE);
   assign o_done  = (st_r == S_T3) && (st_nxt == S_IDLE);
   assign o_count = cnt_r;
endmodule : dsg_dma

// file: testbench/dsg_bus_asserts.sv
// checker: timing relations on the shared dma/glue bus
module dsg_bus_asserts (
   input wire logic i_clk,            // clock
   input wire logic i_rst_n,          // reset, low
   input wire logic addr_oe_n,        // address enable
   input wire logic ctl_oe_n,         // strobe enable
   input wire logic dma_doe_n,        // data enable
   input wire logic rd_n,             // read strobe
   input wire logic wr_n,             // write strobe
   input wire logic bus_grant_ack_n,  // grant
   input wire logic grant_chain_in_n, // chain in
   input wire logic search_mode,      // fly-by
   input wire logic t2_phase,         // second state of a cycle
   input wire logic cs_wait_n,        // shared pin
   input wire logic i_wait_request_n  // wait source
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_idle_addr; bus_grant_ack_n |-> addr_oe_n; endproperty
   a_idle_addr: assert property (p_idle_addr) else $error("addr driven, no grant");
   property p_idle_ctl; (bus_grant_ack_n || grant_chain_in_n) |-> ctl_oe_n; endproperty
   a_idle_ctl: assert property (p_idle_ctl) else $error("strobes driven, not owner");
   property p_strobe_excl; !rd_n |-> wr_n; endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("read and write at once");
   property p_search_rd; (search_mode && !ctl_oe_n) |-> wr_n; endproperty
   a_search_rd: assert property (p_search_rd) else $error("write in search mode");
   property p_rd_t2; $fell(rd_n) |-> t2_phase; endproperty
   a_rd_t2: assert property (p_rd_t2) else $error("read strobe outside second state");
   // two-stage sync: after four wait cycles the strobe must still be held
   property p_wait_hold; (!rd_n && !cs_wait_n) [*4] |=> !rd_n; endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("wait did not stretch");
   property p_mux_wait; !bus_grant_ack_n |-> (cs_wait_n == i_wait_request_n); endproperty
   a_mux_wait: assert property (p_mux_wait) else $error("pin not steered to wait");
   property p_dout_write; !dma_doe_n |-> rd_n; endproperty
   a_dout_write: assert property (p_dout_write) else $error("data driven in read");
   c_write: cover property (!wr_n);
   c_wait: cover property ((!rd_n && !cs_wait_n) [*4]);
   c_fly: cover property (search_mode && !rd_n);
endmodule : dsg_bus_asserts

// file: testbench/tb.sv
// testbench: both bus ends joined, scenario tasks and verdict
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk, i_rst_n = 1'b0, i_start = 1'b0, i_src_io = 1'b0, i_dst_io = 1'b0;
   logic        i_search = 1'b0, i_short = 1'b0, i_cpu_grant_ack_n = 1'b0, i_multi_master = 1'b0;
   logic        i_chain_in_n = 1'b0, i_cpu_io_req_n = 1'b1, i_cpu_fetch_n = 1'b1, i_cpu_rd_n = 1'b1;
   logic        i_wait_request_n = 1'b1, i_intack_vec = 1'b0;
   logic [15:0] i_blk_len = 16'h0000, i_src_addr = 16'h1000, i_dst_addr = 16'h2000;
   logic [15:0] i_cpu_addr = 16'h0000, o_count;
   logic [3:0]  i_extra_wr = 4'h0;
   logic [7:0]  i_sys_data = 8'h5a;
   logic        o_busy, o_done, o_dma_cs_n, o_per_cs_n, o_cpu_buf_oe_n, o_dma_buf_oe_n;
   logic        o_data_out, o_mem_write_fly_n, o_io_write_fly_n, o_mem_read_fly_n;
   logic        o_io_read_fly_n;
   int          fails = 0, n_compared = 0;
   dsg_bus_if dsg_bus_if_inst ();
   dsg_dma dsg_dma_inst (.i_clk, .i_rst_n, .bus(dsg_bus_if_inst), .i_start, .i_blk_len,
      .i_src_addr, .i_dst_addr, .i_src_io, .i_dst_io, .i_search, .i_extra_wr, .i_short,
      .o_busy, .o_done, .o_count);
   dsg_glue dsg_glue_inst (.i_clk, .i_rst_n, .bus(dsg_bus_if_inst), .i_cpu_grant_ack_n,
      .i_multi_master, .i_chain_in_n, .i_cpu_addr, .i_cpu_io_req_n, .i_cpu_fetch_n, .i_cpu_rd_n,
      .i_wait_request_n, .i_intack_vec, .i_sys_data, .o_dma_cs_n, .o_per_cs_n, .o_cpu_buf_oe_n,
      .o_dma_buf_oe_n, .o_data_out, .o_mem_write_fly_n, .o_io_write_fly_n, .o_mem_read_fly_n,
      .o_io_read_fly_n);
   dsg_bus_asserts dsg_bus_asserts_inst (.i_clk, .i_rst_n, .i_wait_request_n,
      .addr_oe_n(dsg_bus_if_inst.addr_oe_n), .ctl_oe_n(dsg_bus_if_inst.ctl_oe_n),
      .dma_doe_n(dsg_bus_if_inst.dma_doe_n), .rd_n(dsg_bus_if_inst.rd_n),
      .wr_n(dsg_bus_if_inst.wr_n), .bus_grant_ack_n(dsg_bus_if_inst.bus_grant_ack_n),
      .grant_chain_in_n(dsg_bus_if_inst.grant_chain_in_n), .t2_phase(dsg_bus_if_inst.t2_phase),
      .search_mode(dsg_bus_if_inst.search_mode), .cs_wait_n(dsg_bus_if_inst.cs_wait_n));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
      n_compared++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : cmp
   task automatic summarize;
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize
   // one block; wait is held low for the first wt cycles, a second start is refused
   task automatic run_blk(input logic [15:0] len, input logic [3:0] xw, input logic sh,
      input logic sr, input int wt, output int cyc, output int nwr, output int nwl,
      output int nfly, output logic mw1);
      logic pw = 1'b1, seen = 1'b0;
      {cyc, nwr, nwl, nfly} = '0;
      mw1 = 1'bx;
      @(negedge i_clk);
      {i_blk_len, i_extra_wr, i_short, i_search, i_start} = {len, xw, sh, sr, 1'b1};
      for (int k = 0; k < 400; k++) begin
         // look a quarter period after the rising edge: the negedge flop has not moved yet
         @(posedge i_clk);
         #10;
         cyc += int'(o_busy);
         nwl += int'(!dsg_bus_if_inst.wr_n);
         nwr += int'(pw && !dsg_bus_if_inst.wr_n);
         nfly += int'(!o_mem_write_fly_n);
         if (!seen && !dsg_bus_if_inst.rd_n) mw1 = o_mem_write_fly_n;
         seen |= !dsg_bus_if_inst.rd_n;
         pw = dsg_bus_if_inst.wr_n;
         if (!dsg_bus_if_inst.wr_n) begin
            cmp("wr_data", 16'(i_sys_data), 16'(dsg_bus_if_inst.dma_dout));
         end
         if (sr && !dsg_bus_if_inst.rd_n) begin
            cmp("io_rd_fly", 16'(!i_src_io), 16'(o_io_read_fly_n));
            cmp("mem_rd_fly", 16'(i_src_io), 16'(o_mem_read_fly_n));
            cmp("io_wr_fly", 16'(i_src_io), 16'(o_io_write_fly_n));
         end
         if (o_done === 1'b1) break;
         @(negedge i_clk);
         i_start = (k == 2);
         i_wait_request_n = (k >= wt);
      end
      // the count register takes its last step on the edge that ends the final state
      @(posedge i_clk);
      #10;
      cmp("o_count", len + 16'h0001, o_count);
      @(negedge i_clk);
      i_wait_request_n = 1'b1;
      repeat (2) @(negedge i_clk);
      cmp("busy_after", 16'h0000, 16'(o_busy));
   endtask : run_blk
   task automatic t_decode;
      logic [7:0] lo;
      logic       ed, ep;
      {i_cpu_grant_ack_n, i_cpu_rd_n} = 2'b10;
      for (int i = 0; i < 32; i++) begin
         @(negedge i_clk);
         lo = {i[3], 4'h0, i[2:0]};
         {i_cpu_addr, i_cpu_io_req_n} = {8'hc3, lo, i[4]};
         #5;
         ed = !(!i[4] && lo[7:2] == dsg_pkg::DMA_IO_ADDR[7:2]);
         ep = !(!i[4] && lo[7:2] == dsg_pkg::PER_IO_ADDR[7:2]);
         cmp("dma_cs_n", 16'(ed), 16'(o_dma_cs_n));
         cmp("per_cs_n", 16'(ep), 16'(o_per_cs_n));
         cmp("data_out", 16'(!(ed && ep)), 16'(o_data_out));
         cmp("cs_wait_n", 16'(ed), 16'(dsg_bus_if_inst.cs_wait_n));
      end
      {i_cpu_io_req_n, i_cpu_rd_n} = 2'b11;
   endtask : t_decode
   task automatic t_own;
      logic own;
      for (int i = 0; i < 8; i++) begin
         @(negedge i_clk);
         {i_multi_master, i_cpu_grant_ack_n, i_chain_in_n, i_intack_vec} = {i[2:0], i[0]};
         #5;
         own = i[2] ? (!i[0] && dsg_bus_if_inst.grant_chain_out_n) : !i[1];
         cmp("dma_buf_oe_n", 16'(!own), 16'(o_dma_buf_oe_n));
         if (!i[2]) cmp("cpu_buf_oe_n", 16'(own), 16'(o_cpu_buf_oe_n));
         if (i[0]) cmp("vec_out", 16'h0001, 16'(o_data_out));
      end
      {i_multi_master, i_cpu_grant_ack_n, i_chain_in_n, i_intack_vec} = 4'h0;
   endtask : t_own
   task automatic t_block;
      int   c, w, l, f;
      logic m;
      run_blk(16'h0002, 4'h0, 1'b0, 1'b0, 0, c, w, l, f, m);
      cmp("writes_len2", 16'h0003, 16'(w));
      cmp("fly_idle", 16'h0000, 16'(f));
      run_blk(16'h0000, 4'h0, 1'b0, 1'b0, 0, c, w, l, f, m);
      cmp("writes_len0", 16'h0001, 16'(w));
   endtask : t_block
   task automatic t_timing;
      int   c0, c1, cw, w, l0, l1, f;
      logic m;
      run_blk(16'h0000, 4'h0, 1'b0, 1'b0, 0, c0, w, l0, f, m);
      run_blk(16'h0000, 4'h2, 1'b0, 1'b0, 0, c1, w, l1, f, m);
      cmp("wr_extra", 16'h0002, 16'(l1 - l0));
      run_blk(16'h0000, 4'h0, 1'b0, 1'b0, 12, cw, w, l1, f, m);
      cmp("wait_longer", 16'h0001, 16'(cw > c0));
      // the short cycle drops the wait check, so it only gains where waits are asked for
      run_blk(16'h0000, 4'h0, 1'b1, 1'b0, 12, c1, w, l1, f, m);
      cmp("short_faster", 16'h0001, 16'(c1 < cw));
   endtask : t_timing
   task automatic t_fly;
      int   c, w, l, f;
      logic m;
      i_src_io = 1'b1;
      run_blk(16'h0001, 4'h0, 1'b0, 1'b1, 0, c, w, l, f, m);
      cmp("search_writes", 16'h0000, 16'(w));
      cmp("fly_mem_write", 16'h0001, 16'(f != 0));
      cmp("fly_lead_edge", 16'h0001, 16'(m));
      i_src_io = 1'b0;
      run_blk(16'h0001, 4'h0, 1'b0, 1'b1, 0, c, w, l, f, m);
      cmp("fly_mem_src", 16'h0000, 16'(f));
   endtask : t_fly
   initial begin
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      @(negedge i_clk);
      t_decode();
      t_own();
      t_block();
      t_timing();
      t_fly();
      summarize();
   end
   // eight blocks of at most 400 cycles each fit well inside this span
   initial begin
      #1000000;
      fails++;
      summarize();
   end
endmodule : tb
